// >>> rtl/pts_gp_timer.sv
// Purpose: one reloadable 16-bit up-counter with optional pin clock
// Assumes: baseTick is a one-cycle pulse on clk; extPin is asynchronous
// Notes: running count holds the inverted reload so the period is reload+1
`timescale 1ns/10ps
module pts_gp_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic baseTick,
  input wire logic extPin,
  input wire logic trigEnable,
  input wire logic trigFalling,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  output logic timeout
);
  logic pinMeta;
  logic pinSync;
  logic pinPrev;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] reload;

  wire logic pinRise = pinSync & ~pinPrev;
  wire logic pinFall = ~pinSync & pinPrev;
  // RL14 pin trigger select
  wire logic extEdge = trigFalling ? pinFall : pinRise;
  wire logic countStep = trigEnable ? extEdge : baseTick;
  wire logic atTop = &count;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
      pinPrev <= 1'b0;
    end else if (ce) begin
      pinMeta <= extPin;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      reload <= '0;
      timeout <= 1'b0;
    end else if (ce) begin
      timeout <= countStep & atTop & ~load;
      if (load) begin
        // RL18 write loads both
        count <= ~loadValue;
        reload <= loadValue;
      end else if (countStep) begin
        // RL6 reload on time-out
        count <= atTop ? ~reload : count + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  reload_on_out_a: assert property (ce && countStep && atTop && !load |=> // RL6
    count == ~reload && timeout) else $error("timeout did not reload");
  load_both_a: assert property (ce && load |=> // RL18
    reload == $past(loadValue) && count == ~$past(loadValue))
    else $error("counter write not taken");
  edge_sel_a: assert property (ce && trigEnable && !extEdge && !load |=> // RL14
    count == $past(count)) else $error("pin mode counted without edge");
endmodule

// >>> rtl/pts_pkg.sv
// Purpose: shared constants for the programmable timer set
// Assumes: 100 MHz system clock, 16-bit core I/O data path
// Notes: virtual indices are reached through the index/data port pair
package pts_pkg;
  // common I/O addresses seen by the core
  localparam logic [4:0] IO_STATUS = 5'h00;
  localparam logic [4:0] IO_INT_ENABLE = 5'h01;
  localparam logic [4:0] IO_INT_REQUEST = 5'h02;
  localparam logic [4:0] IO_VIRT_INDEX = 5'h1e;
  localparam logic [4:0] IO_VIRT_DATA = 5'h1f;
  // virtual register indices
  localparam logic [7:0] VIRT_TIMER_ONE = 8'h00;
  localparam logic [7:0] VIRT_TIMER_TWO = 8'h01;
  localparam logic [7:0] VIRT_RTC_DIV = 8'h02;
  localparam logic [7:0] VIRT_TRIG_CFG = 8'h03;
  // field positions
  localparam int STATUS_GIE_BIT = 7;
  localparam int REQ_PWM = 0;
  localparam int REQ_TIMER_ONE = 1;
  localparam int REQ_TIMER_TWO = 2;
  localparam int REQ_RTC = 3;
  localparam int REQ_BITS = 4;
  localparam int TRIG_ONE_LSB = 0;
  localparam int TRIG_TWO_LSB = 8;
  localparam int TRIG_EN_BIT = 0;
  localparam int TRIG_EDGE_BIT = 1;
  // reset values
  localparam logic [2:0] RTC_DIV_RESET = 3'h0;
  localparam logic [15:0] TRIG_CFG_RESET = 16'h0000;
  localparam logic [7:0] VIRT_INDEX_RESET = 8'h00;
  // rates and derived cycle counts
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int TB_FREQ_KHZ = 32768;
  localparam int PWM_FREQ_KHZ = 32;
  localparam int PWM_DIV = TB_FREQ_KHZ / PWM_FREQ_KHZ;
  localparam int RTC_DIV_BITS = 12;

  // divider select to tap width; code 000 is the 2 ms period
  function automatic logic [3:0] rtc_tap(input logic [2:0] sel);
    logic [3:0] tap;
    tap = 4'h6;
    case (sel)
      3'h1: tap = 4'h1;
      3'h2: tap = 4'h2;
      3'h3: tap = 4'h3;
      3'h4: tap = 4'h5;
      3'h5: tap = 4'h7;
      3'h6: tap = 4'h8;
      3'h7: tap = 4'hc;
      default: tap = 4'h6;
    endcase
    return tap;
  endfunction
endpackage

// >>> rtl/pts_timer_set.sv
// Purpose: audio PWM timer, two general timers and RTC divider
// Assumes: core I/O port on clk; pins and 32 kHz inputs are asynchronous
// Notes: request flags and enables live here so ordering stays exact
// Operation
// RL1 - PWM timer requests at 32 kHz when enabled
// RL2 - auto FIFO divides PWM rate by length
// RL3 - general timers use fixed 32.768 MHz base
// RL4 - 16-bit write-only counter per timer
// RL5 - enabled timer time-out sets request flag
// RL6 - time-out reloads count, keeps counting up
// RL7 - interrupt asserts next clock when globally enabled
// RL8 - request rate is clock over reload+1
// RL9 - RTC input crystal or RC oscillator option
// RL10 - RTC holds a 12-bit divider
// RL11 - RTC period wakes halted core, else requests
// RL12 - wake default on; request 2 ms after reset
// RL13 - halt entry clears divider once
// RL14 - trigger bit0 enables pin, bit1 edge
// RL15 - flags set by hardware, cleared by software
// RL16 - software writes index, then data word
// RL17 - global enable gates all, cleared at reset
// RL18 - counter write loads count and reload
// RL19 - divider select picks eight taps, 000=2ms
`timescale 1ns/10ps
module pts_timer_set #(
  parameter int FIFO_LEN_BITS = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [4:0] ioAddr,
  input wire logic ioWrite,
  input wire logic [15:0] ioWriteData,
  output logic [15:0] ioReadData,
  input wire logic timerOneExtPin,
  input wire logic timerTwoExtPin,
  input wire logic rtcXtalIn,
  input wire logic rtcRcOscIn,
  input wire logic rtcUseRcOsc,
  input wire logic rtcWakeDisable,
  input wire logic coreHalted,
  input wire logic fifoAutoEnable,
  input wire logic [FIFO_LEN_BITS-1:0] fifoLength,
  output logic timerIrq,
  output logic wakeCore
);
  logic [7:0] virtIndex;
  logic [2:0] rtcDivSelect;
  logic [15:0] trigConfig;
  logic globalEnable;
  logic [pts_pkg::REQ_BITS-1:0] enableBits;
  logic [pts_pkg::REQ_BITS-1:0] requestFlags;
  logic [16:0] tbPhase;
  logic tbTick;
  logic [9:0] pwmDiv;
  logic pwmTick;
  logic [FIFO_LEN_BITS-1:0] fifoCount;
  logic rtcMeta;
  logic rtcSync;
  logic rtcPrev;
  logic [pts_pkg::RTC_DIV_BITS-1:0] rtcDivider;
  logic haltPrev;
  logic timerOneOut;
  logic timerTwoOut;

  // register decode
  wire logic wrStrobe = ce & ioWrite;
  wire logic wrIndex = wrStrobe && ioAddr == pts_pkg::IO_VIRT_INDEX;
  wire logic wrData = wrStrobe && ioAddr == pts_pkg::IO_VIRT_DATA;
  wire logic wrStatus = wrStrobe && ioAddr == pts_pkg::IO_STATUS;
  wire logic wrEnable = wrStrobe && ioAddr == pts_pkg::IO_INT_ENABLE;
  wire logic wrRequest = wrStrobe && ioAddr == pts_pkg::IO_INT_REQUEST;
  // RL16 data goes to the last index
  wire logic loadOne = wrData && virtIndex == pts_pkg::VIRT_TIMER_ONE;
  wire logic loadTwo = wrData && virtIndex == pts_pkg::VIRT_TIMER_TWO;
  wire logic wrRtcDiv = wrData && virtIndex == pts_pkg::VIRT_RTC_DIV;
  wire logic wrTrig = wrData && virtIndex == pts_pkg::VIRT_TRIG_CFG;

  wire logic [15:0] readMux =
    (ioAddr == pts_pkg::IO_STATUS) ?
      16'(globalEnable) << pts_pkg::STATUS_GIE_BIT :
    (ioAddr == pts_pkg::IO_INT_ENABLE) ? 16'(enableBits) :
    (ioAddr == pts_pkg::IO_INT_REQUEST) ? 16'(requestFlags) : 16'h0000;

  // RL3 fractional divider for the 32.768 MHz base
  // one bit extra: phase plus step can pass the 17-bit range
  wire logic [17:0] tbSum = {1'b0, tbPhase} + 18'(pts_pkg::TB_FREQ_KHZ);
  wire logic tbWrap = tbSum >= 18'(pts_pkg::CLK_FREQ_KHZ);
  wire logic [16:0] next_tbPhase =
    17'(tbWrap ? tbSum - 18'(pts_pkg::CLK_FREQ_KHZ) : tbSum);

  // RL2 one request per fifoLength PWM periods
  wire logic fifoLast = fifoLength <= FIFO_LEN_BITS'(1) ||
    fifoCount >= fifoLength - FIFO_LEN_BITS'(1);
  wire logic pwmReq = pwmTick & (~fifoAutoEnable | fifoLast);

  // RL9 option picks the 32 kHz source before the synchroniser
  wire logic rtcRaw = rtcUseRcOsc ? rtcRcOscIn : rtcXtalIn;
  wire logic rtcTick = rtcSync & ~rtcPrev;
  // RL19 tap mask from divider select
  wire logic [3:0] rtcTap = pts_pkg::rtc_tap(rtcDivSelect);
  wire logic [pts_pkg::RTC_DIV_BITS-1:0] tapMask =
    (pts_pkg::RTC_DIV_BITS'(1) << rtcTap) - pts_pkg::RTC_DIV_BITS'(1);
  wire logic rtcPeriod = rtcTick && (rtcDivider & tapMask) == tapMask;
  wire logic haltEntry = coreHalted & ~haltPrev;

  // RL11 request only outside halt
  wire logic rtcReq = rtcPeriod & ~coreHalted;
  // RL5 timer flags gated by enable
  wire logic [pts_pkg::REQ_BITS-1:0] reqSet = {
    rtcReq,
    timerTwoOut & enableBits[pts_pkg::REQ_TIMER_TWO],
    timerOneOut & enableBits[pts_pkg::REQ_TIMER_ONE],
    pwmReq & enableBits[pts_pkg::REQ_PWM]};
  // RL15 software clears by writing zero; a new event wins
  wire logic [pts_pkg::REQ_BITS-1:0] next_requestFlags =
    (wrRequest ? requestFlags & ioWriteData[pts_pkg::REQ_BITS-1:0] :
     requestFlags) | reqSet;
  // RL17 global gate on enabled flags
  wire logic next_timerIrq = globalEnable & |(next_requestFlags & enableBits);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      virtIndex <= pts_pkg::VIRT_INDEX_RESET;
      rtcDivSelect <= pts_pkg::RTC_DIV_RESET;
      trigConfig <= pts_pkg::TRIG_CFG_RESET;
      globalEnable <= 1'b0;
      enableBits <= '0;
      ioReadData <= 16'h0000;
    end else if (ce) begin
      ioReadData <= readMux;
      if (wrIndex) virtIndex <= ioWriteData[7:0];
      if (wrRtcDiv) rtcDivSelect <= ioWriteData[2:0];
      if (wrTrig) trigConfig <= ioWriteData;
      if (wrStatus) globalEnable <= ioWriteData[pts_pkg::STATUS_GIE_BIT];
      if (wrEnable) enableBits <= ioWriteData[pts_pkg::REQ_BITS-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tbPhase <= '0;
      tbTick <= 1'b0;
      pwmDiv <= '0;
      pwmTick <= 1'b0;
      fifoCount <= '0;
    end else if (ce) begin
      tbPhase <= next_tbPhase;
      tbTick <= tbWrap;
      pwmTick <= 1'b0;
      // RL1 1024 base ticks per 32 kHz period
      if (tbTick) begin
        pwmDiv <= (pwmDiv == 10'(pts_pkg::PWM_DIV - 1)) ? '0 : pwmDiv + 1'b1;
        pwmTick <= pwmDiv == 10'(pts_pkg::PWM_DIV - 1);
      end
      if (pwmTick) fifoCount <= pwmReq ? '0 : fifoCount + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rtcMeta <= 1'b0;
      rtcSync <= 1'b0;
      rtcPrev <= 1'b0;
      rtcDivider <= '0;
      haltPrev <= 1'b0;
      wakeCore <= 1'b0;
      requestFlags <= '0;
      timerIrq <= 1'b0;
    end else if (ce) begin
      rtcMeta <= rtcRaw;
      rtcSync <= rtcMeta;
      rtcPrev <= rtcSync;
      haltPrev <= coreHalted;
      // RL13 halt entry restarts the divider
      if (haltEntry) rtcDivider <= '0;
      // RL10 12-bit divider
      else if (rtcTick) rtcDivider <= rtcDivider + 1'b1;
      // RL12 wake is on unless the option removes it
      wakeCore <= rtcPeriod & coreHalted & ~rtcWakeDisable;
      requestFlags <= next_requestFlags;
      // RL7 irq registers from next_requestFlags, so it rises in the same clock as the flag
      timerIrq <= next_timerIrq;
    end
  end

  // RL4 RL8 two counters share the base tick
  pts_gp_timer #(.WIDTH(16)) timerOne (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .baseTick(tbTick),
    .extPin(timerOneExtPin),
    .trigEnable(trigConfig[pts_pkg::TRIG_ONE_LSB + pts_pkg::TRIG_EN_BIT]),
    .trigFalling(trigConfig[pts_pkg::TRIG_ONE_LSB + pts_pkg::TRIG_EDGE_BIT]),
    .load(loadOne),
    .loadValue(ioWriteData),
    .timeout(timerOneOut)
  );

  pts_gp_timer #(.WIDTH(16)) timerTwo (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .baseTick(tbTick),
    .extPin(timerTwoExtPin),
    .trigEnable(trigConfig[pts_pkg::TRIG_TWO_LSB + pts_pkg::TRIG_EN_BIT]),
    .trigFalling(trigConfig[pts_pkg::TRIG_TWO_LSB + pts_pkg::TRIG_EDGE_BIT]),
    .load(loadTwo),
    .loadValue(ioWriteData),
    .timeout(timerTwoOut)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence timeoutSeen;
    ce && timerOneOut && enableBits[pts_pkg::REQ_TIMER_ONE];
  endsequence
  sequence irqFollows;
    ##1 ce [*1] ##0 timerIrq;
  endsequence

  pwm_request_a: assert property (ce && pwmReq && enableBits[0] |=> // RL1
    requestFlags[pts_pkg::REQ_PWM]) else $error("pwm flag not set");
  fifo_spacing_a: assert property (ce && pwmTick && fifoAutoEnable && // RL2
    fifoLength > 1 && fifoCount < fifoLength - 1 |-> !pwmReq)
    else $error("fifo rate not divided");
  base_tick_a: assert property (ce && tbTick |=> !tbTick) // RL3
    else $error("base tick faster than half rate");
  timer_flag_a: assert property (timeoutSeen |=> // RL5
    requestFlags[pts_pkg::REQ_TIMER_ONE]) else $error("timer flag missing");
  irq_next_a: assert property (timeoutSeen ##0 globalEnable && // RL7
    !wrStatus && !wrEnable |-> irqFollows) else $error("irq late");
  flag_hold_a: assert property (|($past(requestFlags) & ~requestFlags) // RL15
    |-> $past(wrRequest)) else $error("flag cleared by hardware");
  gate_off_a: assert property (!globalEnable |=> !timerIrq) // RL17
    else $error("irq while globally disabled");
  halt_clear_a: assert property (ce && haltEntry |=> // RL13
    rtcDivider == '0) else $error("divider not cleared on halt");
  rtc_wake_a: assert property (ce && rtcPeriod && coreHalted && // RL11
    !rtcWakeDisable |=> wakeCore && !$changed(requestFlags[pts_pkg::REQ_RTC]))
    else $error("halted core not woken");
endmodule

// >>> tb/programmable_timer_set_tb_top.sv
// Purpose: self-checking bench for the programmable timer set
// Assumes: inputs other than the free-running crystal change on the falling clock edge
// Notes: long RTC taps are skipped; select 001 keeps the run short
`timescale 1ns/10ps
module programmable_timer_set_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] ioAddr;
  logic ioWrite;
  logic [15:0] ioWriteData;
  logic [15:0] ioReadData;
  logic pinOne = 1'b0;
  logic pinTwo = 1'b1;
  logic xtal = 1'b0;
  logic halted = 1'b0;
  logic ce = 1'b1;
  // idle RC source: selecting it must stop the RTC
  logic rcOsc = 1'b0;
  logic useRc = 1'b0;
  logic wakeDis = 1'b0;
  logic fifoEn = 1'b0;
  logic [7:0] fifoLen = 8'h02;
  logic timerIrq;
  logic wakeCore;
  logic [15:0] rv;
  int error_cnt = 0;
  int checks = 0;

  always #5 clk = ~clk;
  // 32768 Hz crystal, unrelated in phase to clk
  always #15259 xtal = ~xtal;

  pts_core_model pts_core_model_i (.clk(clk), .ioReadData(ioReadData),
    .ioAddr(ioAddr), .ioWrite(ioWrite), .ioWriteData(ioWriteData));

  pts_timer_set pts_timer_set_i (.clk(clk), .reset_n(reset_n), .ce(ce),
    .ioAddr(ioAddr), .ioWrite(ioWrite), .ioWriteData(ioWriteData),
    .ioReadData(ioReadData), .timerOneExtPin(pinOne),
    .timerTwoExtPin(pinTwo), .rtcXtalIn(xtal), .rtcRcOscIn(rcOsc),
    .rtcUseRcOsc(useRc), .rtcWakeDisable(wakeDis), .coreHalted(halted),
    .fifoAutoEnable(fifoEn), .fifoLength(fifoLen), .timerIrq(timerIrq),
    .wakeCore(wakeCore));

  task automatic test_done();
    $display("checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic flag_bit(input int b, output logic v);
    pts_core_model_i.rd(pts_pkg::IO_INT_REQUEST, rv);
    v = rv[b];
  endtask

  // bounded poll of one request flag
  task automatic wait_flag(input int b, input int limit);
    logic v;
    v = 1'b0;
    for (int i = 0; i < limit && v !== 1'b1; i++) flag_bit(b, v);
    if (v !== 1'b1) begin
      check(16'h0000, 16'h0001);
      test_done();
    end
  endtask

  task automatic pulse_one(input int n);
    repeat (n) begin
      @(negedge clk) pinOne = 1'b1;
      wait_cycles(4);
      pinOne = 1'b0;
      wait_cycles(4);
    end
    wait_cycles(8);
  endtask

  task automatic reset_values();
    pts_core_model_i.rd(pts_pkg::IO_STATUS, rv);
    check(rv, 16'h0000);
    pts_core_model_i.rd(pts_pkg::IO_INT_ENABLE, rv);
    check(rv, 16'h0000);
    check({15'h0000, timerIrq}, 16'h0000);
  endtask

  task automatic timer_one_pin();
    logic v;
    pts_core_model_i.wr(pts_pkg::IO_INT_ENABLE, 16'h0002);
    pts_core_model_i.vwr(pts_pkg::VIRT_TRIG_CFG, 16'h0001);
    pts_core_model_i.vwr(pts_pkg::VIRT_TIMER_ONE, 16'h0004);
    pulse_one(4);
    flag_bit(pts_pkg::REQ_TIMER_ONE, v);
    check({15'h0000, v}, 16'h0000);
    // low clock enable freezes the synchroniser, so the edge is lost
    ce = 1'b0;
    pulse_one(1);
    ce = 1'b1;
    flag_bit(pts_pkg::REQ_TIMER_ONE, v);
    check({15'h0000, v}, 16'h0000);
    pulse_one(1);
    flag_bit(pts_pkg::REQ_TIMER_ONE, v);
    check({15'h0000, v}, 16'h0001);
    check({15'h0000, timerIrq}, 16'h0000);
    pts_core_model_i.wr(pts_pkg::IO_STATUS, 16'h0080);
    wait_cycles(2);
    check({15'h0000, timerIrq}, 16'h0001);
    // write of one keeps, write of zero clears
    pts_core_model_i.wr(pts_pkg::IO_INT_REQUEST, 16'hffff);
    flag_bit(pts_pkg::REQ_TIMER_ONE, v);
    check({15'h0000, v}, 16'h0001);
    pts_core_model_i.wr(pts_pkg::IO_INT_REQUEST, 16'hfffd);
    flag_bit(pts_pkg::REQ_TIMER_ONE, v);
    check({15'h0000, v}, 16'h0000);
    wait_cycles(2);
    check({15'h0000, timerIrq}, 16'h0000);
    // reloaded count gives the same period again
    pulse_one(4);
    flag_bit(pts_pkg::REQ_TIMER_ONE, v);
    check({15'h0000, v}, 16'h0000);
    pulse_one(1);
    flag_bit(pts_pkg::REQ_TIMER_ONE, v);
    check({15'h0000, v}, 16'h0001);
    pts_core_model_i.wr(pts_pkg::IO_STATUS, 16'h0000);
  endtask

  task automatic timer_two_falling();
    logic v;
    pts_core_model_i.wr(pts_pkg::IO_INT_ENABLE, 16'h0000);
    pts_core_model_i.vwr(pts_pkg::VIRT_TRIG_CFG, 16'h0301);
    pts_core_model_i.vwr(pts_pkg::VIRT_TIMER_TWO, 16'h0002);
    for (int k = 0; k < 6; k++) begin
      if (k == 3) begin
        pts_core_model_i.wr(pts_pkg::IO_INT_ENABLE, 16'h0004);
      end
      @(negedge clk) pinTwo = 1'b0;
      wait_cycles(8);
      flag_bit(pts_pkg::REQ_TIMER_TWO, v);
      // only the last falling edge of each period may set the flag
      check({15'h0000, v}, {15'h0000, k == 5});
      @(negedge clk) pinTwo = 1'b1;
      wait_cycles(8);
    end
  endtask

  // cycles from a flag clear to the next pwm flag, two-cycle polls
  task automatic pwm_gap(output int n);
    logic v;
    v = 1'b0;
    n = 2;
    pts_core_model_i.wr(pts_pkg::IO_INT_REQUEST, 16'h0000);
    while (n < 8000 && v !== 1'b1) begin
      flag_bit(pts_pkg::REQ_PWM, v);
      n += 2;
    end
    if (v !== 1'b1) begin
      check(16'h0000, 16'h0001);
      test_done();
    end
  endtask

  task automatic pwm_rate();
    int n;
    pts_core_model_i.wr(pts_pkg::IO_INT_ENABLE, 16'h0001);
    pts_core_model_i.wr(pts_pkg::IO_INT_REQUEST, 16'h0000);
    // one request per 1024 base ticks, 3125 clocks
    wait_flag(pts_pkg::REQ_PWM, 2200);
    pwm_gap(n);
    check({15'h0000, n >= 3120 && n <= 3130}, 16'h0001);
    // fifo of two halves the request rate
    fifoEn = 1'b1;
    pwm_gap(n);
    check({15'h0000, n >= 6245 && n <= 6255}, 16'h0001);
  endtask

  task automatic rtc_wake();
    logic seen;
    logic v;
    seen = 1'b0;
    @(negedge clk) useRc = 1'b1;
    wait_cycles(8);
    pts_core_model_i.vwr(pts_pkg::VIRT_RTC_DIV, 16'h0001);
    pts_core_model_i.wr(pts_pkg::IO_INT_REQUEST, 16'h0000);
    // over two crystal periods: the idle source must give nothing
    wait_cycles(7000);
    flag_bit(pts_pkg::REQ_RTC, v);
    check({15'h0000, v}, 16'h0000);
    @(negedge clk) useRc = 1'b0;
    wait_flag(pts_pkg::REQ_RTC, 5000);
    check(16'h0001, 16'h0001);
    pts_core_model_i.wr(pts_pkg::IO_INT_REQUEST, 16'h0000);
    @(negedge clk) halted = 1'b1;
    for (int i = 0; i < 10000 && seen !== 1'b1; i++) begin
      @(negedge clk);
      seen = wakeCore;
    end
    check({15'h0000, seen}, 16'h0001);
    if (seen !== 1'b1) test_done();
    @(negedge clk);
    check({15'h0000, wakeCore}, 16'h0000);
    flag_bit(pts_pkg::REQ_RTC, v);
    check({15'h0000, v}, 16'h0000);
    // option removes the wake over a full period
    wakeDis = 1'b1;
    seen = 1'b0;
    for (int i = 0; i < 7000; i++) begin
      @(negedge clk);
      seen = seen | wakeCore;
    end
    check({15'h0000, seen}, 16'h0000);
    wakeDis = 1'b0;
    @(negedge clk) halted = 1'b0;
  endtask

  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    wait_cycles(2);
    reset_values();
    timer_one_pin();
    timer_two_falling();
    pwm_rate();
    rtc_wake();
    test_done();
  end
endmodule

// >>> tb/pts_core_model.sv
// Purpose: core side of the I/O port, writes and reads timer registers
// Assumes: requests change at the falling edge, sampled at the rising
// Notes: released write data shows the inverse of the last word
`timescale 1ns/10ps
module pts_core_model (
  input wire logic clk,
  input wire logic [15:0] ioReadData,
  output logic [4:0] ioAddr,
  output logic ioWrite,
  output logic [15:0] ioWriteData
);
  initial begin
    ioAddr = pts_pkg::IO_INT_REQUEST;
    ioWrite = 1'b0;
    ioWriteData = 16'h0000;
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    ioAddr = a;
    ioWrite = 1'b1;
    ioWriteData = d;
    @(negedge clk);
    ioWrite = 1'b0;
    ioWriteData = ~d;
    ioAddr = pts_pkg::IO_INT_REQUEST;
  endtask

  task automatic vwr(input logic [7:0] idx, input logic [15:0] d);
    wr(pts_pkg::IO_VIRT_INDEX, {8'h00, idx});
    wr(pts_pkg::IO_VIRT_DATA, d);
  endtask

  // read data is registered, so it lands one cycle after the address
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    ioAddr = a;
    @(negedge clk);
    d = ioReadData;
  endtask
endmodule
